/* include/swc_pkg.sv */
// Shared constants and types for the secondary CPU wake control block
`default_nettype none
package swc_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned VEC_W    = 8;  // Wake vector carried by a wake message
  localparam int unsigned KIND_W   = 2;  // Message kind code width
  localparam int unsigned STRAP_CYC = 3; // Cycles before the role strap is trusted

  // ==========================================================================
  // Interprocessor message kinds from the local interrupt unit
  typedef logic [KIND_W-1:0] swc_kind_t;
  localparam swc_kind_t KIND_OTHER = 2'h0;
  localparam swc_kind_t KIND_INIT  = 2'h1;
  localparam swc_kind_t KIND_WAKE  = 2'h2;

  // ==========================================================================
  // Reset values
  localparam logic [VEC_W-1:0] VEC_RST  = 8'h00;
  localparam logic [1:0]       STRAP_RST = 2'h0;

  // ==========================================================================
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_STRAP = 4'h1,  // Catching the role strap after reset
    ST_HALT  = 4'h2,  // Secondary parked, waiting for a wake message
    ST_INIT  = 4'h4,  // Applying an init
    ST_RUN   = 4'h8   // Executing
  } swc_state_t;

endpackage
`default_nettype wire

/* include/swc_evt_if.sv */
// Event bundle from the message front end to the wake sequencer
`default_nettype none
interface swc_evt_if;
  import swc_pkg::*;

  logic             init_evt;     // Init from pin or message, one-cycle pulse
  logic             wake_evt;     // Wake vector message, one-cycle pulse
  logic [VEC_W-1:0] wake_vec;     // Vector of the wake message
  logic             role_primary; // Synchronised role strap level

  modport src (output init_evt, output wake_evt, output wake_vec, output role_primary);
  modport dst (input init_evt, input wake_evt, input wake_vec, input role_primary);
endinterface
`default_nettype wire

/* verilog/swc_msg_front.sv */
// Init pin synchroniser, strap synchroniser and message decode
`default_nettype none
module swc_msg_front
  import swc_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire logic                init_pin,
  input  wire logic                role_pin,
  input  wire logic                msg_valid,
  input  wire swc_pkg::swc_kind_t  msg_kind,
  input  wire logic [VEC_W-1:0]    msg_vector,
  swc_evt_if.src                   evt
);

  // ==========================================================================
  // Pin synchronisers
  logic       init_meta;
  logic       init_sync;
  logic       init_prev;
  logic       role_meta;
  logic       role_sync;
  logic       next_init_evt;
  logic       next_wake_evt;
  logic [VEC_W-1:0] next_wake_vec;
  logic       init_evt_q;
  logic       wake_evt_q;
  logic [VEC_W-1:0] wake_vec_q;

  // First stages feed only the second stages
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      init_meta <= 1'b0;
      init_sync <= 1'b0;
      init_prev <= 1'b0;
      role_meta <= 1'b0;
      role_sync <= 1'b0;
    end else begin
      init_meta <= init_pin;
      init_sync <= init_meta;
      init_prev <= init_sync;
      role_meta <= role_pin;
      role_sync <= role_meta;
    end
  end

  // ==========================================================================
  // Event decode
  // same init effect
  always_comb begin
    next_init_evt = (init_sync & ~init_prev) | (msg_valid & (msg_kind == KIND_INIT));
    next_wake_evt = msg_valid & (msg_kind == KIND_WAKE);
    next_wake_vec = next_wake_evt ? msg_vector : wake_vec_q;
  end

  // Registered so the sequencer sees clean pulses
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      init_evt_q <= 1'b0;
      wake_evt_q <= 1'b0;
      wake_vec_q <= VEC_RST;
    end else begin
      init_evt_q <= next_init_evt;
      wake_evt_q <= next_wake_evt;
      wake_vec_q <= next_wake_vec;
    end
  end

  assign evt.init_evt     = init_evt_q;
  assign evt.wake_evt     = wake_evt_q;
  assign evt.wake_vec     = wake_vec_q;
  assign evt.role_primary = role_sync;

endmodule
`default_nettype wire

/* verilog/swc_wake_ctrl.sv */
// Wake sequencer for a processor started by init and wake vector messages
//
// What this block does
// - As secondary, every reset or init needs a wake message before running.
// - As secondary, reset or init parks in halt, never the reset vector.
// - Init from the pin and init message have identical effect.
// - Init arriving while halted is latched pending until a wake message.
// - After a wake is accepted, inits still act, further wake messages dropped.
// - Wake messages accepted again only after a new reset or init.
// - As primary, every wake message is dropped, pulsing wake_dropped with no other state change.
`default_nettype none
module swc_wake_ctrl
  import swc_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire logic                init_pin,
  input  wire logic                role_pin,
  input  wire logic                msg_valid,
  input  wire swc_pkg::swc_kind_t  msg_kind,
  input  wire logic [VEC_W-1:0]    msg_vector,
  output logic                     cpu_run,
  output logic                     cpu_halted,
  output logic                     reset_fetch,
  output logic                     wake_fetch,
  output logic [VEC_W-1:0]         wake_vector,
  output logic                     init_pending,
  output logic                     wake_armed,
  output logic                     wake_dropped,
  output logic                     role_primary
);

  // ==========================================================================
  // Front end
  swc_evt_if evt ();

  swc_msg_front u_front (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .init_pin   (init_pin),
    .role_pin   (role_pin),
    .msg_valid  (msg_valid),
    .msg_kind   (msg_kind),
    .msg_vector (msg_vector),
    .evt        (evt)
  );

  // ==========================================================================
  // Sequencer state
  swc_state_t       state;
  swc_state_t       next_state;
  logic [1:0]       strap_cnt;
  logic [1:0]       next_strap_cnt;
  logic             primary;
  logic             next_primary;
  logic             pending;
  logic             next_pending;
  logic             armed;
  logic             next_armed;
  logic             rst_fetch_q;
  logic             next_rst_fetch;
  logic             wake_fetch_q;
  logic             next_wake_fetch;
  logic [VEC_W-1:0] vec_q;
  logic [VEC_W-1:0] next_vec;
  logic             drop_q;
  logic             next_drop;

  // Next-state logic; an init in the same cycle as a wake is kept, except in ST_STRAP and in ST_INIT as primary
  always_comb begin
    next_state      = state;
    next_strap_cnt  = strap_cnt;
    next_primary    = primary;
    next_pending    = pending;
    next_armed      = armed;
    next_rst_fetch  = 1'b0;
    next_wake_fetch = 1'b0;
    next_vec        = vec_q;
    next_drop       = 1'b0;
    case (state)
      ST_STRAP: begin
        // Strap needs the synchroniser to fill before it is trusted
        if (strap_cnt == 2'(STRAP_CYC - 1)) begin
          next_primary = evt.role_primary;
          if (evt.role_primary) begin
            next_state     = ST_RUN;
            next_rst_fetch = 1'b1;
          end else begin
            next_state = ST_HALT;
            next_armed = 1'b1;
          end
        end else begin
          next_strap_cnt = strap_cnt + 2'h1;
        end
      end
      ST_HALT: begin
        if (evt.init_evt) begin
          next_pending = 1'b1;
        end
        if (evt.wake_evt && armed) begin
          next_state      = ST_RUN;
          next_wake_fetch = 1'b1;
          next_vec        = evt.wake_vec;
          next_armed      = 1'b0;
        end
      end
      ST_INIT: begin
        if (primary) begin
          // Primary restarts from the reset vector
          next_state     = ST_RUN;
          next_rst_fetch = 1'b1;
        end else begin
          next_state = ST_HALT;
          next_armed = 1'b1;
          if (evt.init_evt) begin
            next_pending = 1'b1;
          end
        end
        if (evt.wake_evt) begin
          next_drop = 1'b1;
        end
      end
      ST_RUN: begin
        if (evt.init_evt || pending) begin
          next_state   = ST_INIT;
          next_pending = 1'b0;
        end
        if (evt.wake_evt) begin
          next_drop = 1'b1;
        end
      end
      default: begin
        next_state = ST_STRAP;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state        <= ST_STRAP;
      strap_cnt    <= STRAP_RST;
      primary      <= 1'b0;
      pending      <= 1'b0;
      armed        <= 1'b0;
      rst_fetch_q  <= 1'b0;
      wake_fetch_q <= 1'b0;
      vec_q        <= VEC_RST;
      drop_q       <= 1'b0;
    end else begin
      state        <= next_state;
      strap_cnt    <= next_strap_cnt;
      primary      <= next_primary;
      pending      <= next_pending;
      armed        <= next_armed;
      rst_fetch_q  <= next_rst_fetch;
      wake_fetch_q <= next_wake_fetch;
      vec_q        <= next_vec;
      drop_q       <= next_drop;
    end
  end

  // ==========================================================================
  // Outputs, all from registers
  assign cpu_run      = (state == ST_RUN);
  assign cpu_halted   = (state == ST_HALT);
  assign reset_fetch  = rst_fetch_q;
  assign wake_fetch   = wake_fetch_q;
  assign wake_vector  = vec_q;
  assign init_pending = pending;
  assign wake_armed   = armed;
  assign wake_dropped = drop_q;
  assign role_primary = primary;

endmodule
`default_nettype wire

/* verif/swc_wake_monitor.sv */
// Checker of wake sequencing at the top ports
`default_nettype none
module swc_wake_monitor
  import swc_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               resetn,
  input wire logic               init_pin,
  input wire logic               role_pin,
  input wire logic               msg_valid,
  input wire swc_pkg::swc_kind_t msg_kind,
  input wire logic [VEC_W-1:0]   msg_vector,
  input wire logic               cpu_run,
  input wire logic               cpu_halted,
  input wire logic               reset_fetch,
  input wire logic               wake_fetch,
  input wire logic [VEC_W-1:0]   wake_vector,
  input wire logic               init_pending,
  input wire logic               wake_armed,
  input wire logic               wake_dropped,
  input wire logic               role_primary
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Decoded message kinds
  wire logic wk = msg_valid && msg_kind == KIND_WAKE;
  wire logic ini = msg_valid && msg_kind == KIND_INIT;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Pending init acts right after the wake, then parks again
  sequence s_clear;
    !init_pending && !cpu_run ##1 cpu_halted && wake_armed;
  endsequence
  // ==========================================================================
  // Properties
  a_no_reset_fetch: assert property (
    reset_fetch |-> role_primary && cpu_run) else $error("reset fetch off primary run");
  a_wake_accept: assert property (
    wk && cpu_halted && wake_armed |-> ##2 wake_fetch && cpu_run
      && wake_vector == $past(msg_vector, 2)) else $error("wake not taken");
  a_wake_dropped: assert property (
    wk && cpu_run |-> ##2 wake_dropped && !wake_fetch) else $error("wake not dropped");
  a_primary_ignore: assert property (
    wk && role_primary |-> ##2 !wake_fetch && $stable(cpu_run)) else $error("primary woke");
  a_fetch_armed: assert property (
    wake_fetch |-> $past(cpu_halted) && $past(wake_armed)) else $error("fetch unarmed");
  a_init_latched: assert property (
    ini && cpu_halted && !$past(msg_valid) |-> ##2 init_pending) else $error("init lost");
  a_pending_clear: assert property (
    init_pending && wake_fetch |=> s_clear) else $error("pending init not acted");
  a_pin_init: assert property (
    $rose(init_pin) && cpu_run && !role_primary |-> ##[2:8] cpu_halted)
    else $error("pin init not parked");
endmodule
bind swc_wake_ctrl swc_wake_monitor u_mon (.*);
`default_nettype wire

/* verif/swc_boot_model.sv */
// Boot processor model sending messages to the wake control
`default_nettype none
module swc_boot_model
  import swc_pkg::*;
#(
  parameter int INIT_DLY = 40,  // Shortened settle wait after init
  parameter int WAKE_DLY = 8    // Shortened wait after the wake message
)
(
  input  wire logic               ref_clk,
  output var logic                msg_valid,
  output var swc_pkg::swc_kind_t  msg_kind,
  output var logic [VEC_W-1:0]    msg_vector
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    msg_valid = 1'b0;
    msg_kind = KIND_OTHER;
    msg_vector = VEC_RST;
  end
  // One message; released lines show the inverse so stale data never matches
  task automatic send(input swc_kind_t k, input logic [VEC_W-1:0] v);
    @(negedge ref_clk);
    msg_valid = 1'b1;
    msg_kind = k;
    msg_vector = v;
    @(negedge ref_clk);
    msg_valid = 1'b0;
    msg_kind = ~k;
    msg_vector = ~v;
  endtask
  // init, settle, wake, two waits, then caller confirms
  task automatic wake_seq(input logic [VEC_W-1:0] v);
    send(KIND_INIT, 8'h00);
    repeat (INIT_DLY) @(negedge ref_clk);
    send(KIND_WAKE, v);
    repeat (2 * WAKE_DLY) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

/* verif/wake_vector_message_wake_control_bench.sv */
// Self-checking bench for the wake sequencer
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module wake_vector_message_wake_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import swc_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, init_pin = 1'b0, role_pin = 1'b0;
  logic msg_valid, cpu_run, cpu_halted, reset_fetch, wake_fetch;
  logic init_pending, wake_armed, wake_dropped, role_primary;
  swc_kind_t msg_kind;
  logic [VEC_W-1:0] msg_vector, wake_vector;
  int fail_count = 0, check_count = 0, i;
  swc_wake_ctrl DUT (.*);
  swc_boot_model bp (.*);
  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;
  // ==========================================================================
  // Helpers
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic give_up();
    if (i >= 20) begin
      fail_count++;
      summarize();
    end
  endtask
  // Strap is held across reset so it is stable when caught
  task automatic restart(input logic role);
    @(negedge ref_clk);
    resetn = 1'b0;
    role_pin = role;
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (6) @(negedge ref_clk);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_boot();
    restart(1'b0);
    `CHK(cpu_halted, 1'b1)
    `CHK(cpu_run, 1'b0)
    // Fetch pulse stands only in the second cycle after the message
    bp.send(KIND_WAKE, 8'h5a);
    repeat (1) @(negedge ref_clk);
    `CHK(wake_fetch, 1'b1)
    `CHK(wake_vector, 8'h5a)
    bp.send(KIND_WAKE, 8'ha5);
    repeat (1) @(negedge ref_clk);
    `CHK(wake_dropped, 1'b1)
    `CHK(wake_vector, 8'h5a)
  endtask
  task automatic t_pending();
    restart(1'b0);
    bp.send(KIND_INIT, 8'h00);
    repeat (2) @(negedge ref_clk);
    `CHK(init_pending, 1'b1)
    // Run lasts one cycle before the pending init takes effect
    bp.send(KIND_WAKE, 8'h3c);
    repeat (1) @(negedge ref_clk);
    `CHK(cpu_run, 1'b1)
    @(negedge ref_clk);
    `CHK(init_pending, 1'b0)
    @(negedge ref_clk);
    `CHK(wake_armed, 1'b1)
    bp.wake_seq(8'hc3);
    `CHK(wake_vector, 8'hc3)
    `CHK(cpu_halted, 1'b1)
  endtask
  // Init from the pin while running; mirrors the message case
  task automatic t_pin();
    bp.send(KIND_WAKE, 8'h77);
    repeat (3) @(negedge ref_clk);
    `CHK(cpu_run, 1'b1)
    init_pin = 1'b1;
    repeat (4) @(negedge ref_clk);
    init_pin = 1'b0;
    for (i = 0; i < 20 && cpu_halted !== 1'b1; i++) @(negedge ref_clk);
    give_up();
    `CHK(wake_armed, 1'b1)
    bp.send(KIND_WAKE, 8'h88);
    repeat (1) @(negedge ref_clk);
    `CHK(wake_fetch, 1'b1)
  endtask
  task automatic t_primary();
    restart(1'b1);
    `CHK(role_primary, 1'b1)
    `CHK(cpu_run, 1'b1)
    bp.send(KIND_WAKE, 8'h99);
    repeat (1) @(negedge ref_clk);
    `CHK(wake_fetch, 1'b0)
    `CHK(wake_vector, 8'h00)
    `CHK(wake_dropped, 1'b1)
    `CHK(cpu_run, 1'b1)
    bp.send(KIND_INIT, 8'h00);
    for (i = 0; i < 20 && reset_fetch !== 1'b1; i++) @(negedge ref_clk);
    give_up();
    `CHK(cpu_run, 1'b1)
    // Restart fetch is a single-cycle pulse
    @(negedge ref_clk);
    `CHK(reset_fetch, 1'b0)
    `CHK(cpu_halted, 1'b0)
  endtask
  // Main sequence
  initial begin
    t_boot();
    t_pending();
    t_pin();
    t_primary();
    summarize();
  end
endmodule
`default_nettype wire
